// [core/mmio_ports.sv]
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module mmio_ports (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Mode straps and standby
    input wire logic [2:0] mode_pins,
    input wire logic hw_standby_n,
    input wire logic sw_standby,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Clock sources for port one pins zero and one
    input wire logic phi_clock,
    input wire logic e_clock,
    // External bus side
    input wire mmio_pkg::mmio_busctl_s bus_ctl,
    input wire logic [7:0] ext_data_out,
    input wire logic ext_data_drive,
    output logic [7:0] ext_data_in,
    // Port one function outputs
    output mmio_pkg::mmio_p1func_s p1_func,
    // Port one pins
    input wire logic [7:0] p1_in,
    output logic [7:0] p1_out,
    output logic [7:0] p1_oe_n,
    // Port two pins
    input wire logic [4:0] p2_in,
    output logic [4:0] p2_out,
    output logic [4:0] p2_oe_n,
    // Port three pins
    input wire logic [7:0] p3_in,
    output logic [7:0] p3_out,
    output logic [7:0] p3_oe_n
);

    // Reset release synchroniser
    logic rst_s1;
    logic rst_n;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // Pin input synchronisers; first stage feeds only the second
    logic [7:0] p1_s1;
    logic [7:0] p1_sync;
    logic [4:0] p2_s1;
    logic [4:0] p2_sync;
    logic [7:0] p3_s1;
    logic [7:0] p3_sync;
    logic [2:0] mode_s1;
    logic [2:0] mode_sync;
    logic hws_s1;
    logic hws_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            p1_s1 <= 8'h00;
            p1_sync <= 8'h00;
            p2_s1 <= 5'h00;
            p2_sync <= 5'h00;
            p3_s1 <= 8'h00;
            p3_sync <= 8'h00;
            mode_s1 <= 3'h0;
            mode_sync <= 3'h0;
            hws_s1 <= 1'b1;
            hws_sync_n <= 1'b1;
        end else begin
            p1_s1 <= p1_in;
            p1_sync <= p1_s1;
            p2_s1 <= p2_in;
            p2_sync <= p2_s1;
            p3_s1 <= p3_in;
            p3_sync <= p3_s1;
            mode_s1 <= mode_pins;
            mode_sync <= mode_s1;
            hws_s1 <= hw_standby_n;
            hws_sync_n <= hws_s1;
        end
    end

    // Mode straps caught once, after the synchroniser has filled
    logic [1:0] mode_wait;
    logic [2:0] mode;
    logic mode_taken;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_wait <= 2'h0;
            mode_taken <= 1'b0;
            mode <= mmio_pkg::MODE_SINGLE;
        end else if (!mode_taken) begin
            mode_wait <= mode_wait + 2'h1;
            if (mode_wait == mmio_pkg::MODE_SETTLE) begin
                mode <= mode_sync;
                mode_taken <= 1'b1;
            end
        end
    end

    // Mode decode; unlisted codes fall back to single-chip pins
    wire expanded = mode_taken && (mode >= mmio_pkg::MODE_EXP_LO) && (mode <= mmio_pkg::MODE_EXP_HI);
    wire hw_standby = !hws_sync_n;

    // Bus phase machine; reads take one wait state so writes land first
    mmio_pkg::mmio_phase_e phase;
    mmio_pkg::mmio_phase_e next_phase;
    logic [31:0] ph_addr;
    wire accept = hsel && htrans[1] && hready;

    always_comb begin
        next_phase = phase;
        case (phase)
            mmio_pkg::PH_READ_WAIT: begin
                next_phase = mmio_pkg::PH_READ_DONE;
            end
            default: begin
                if (accept && hwrite) begin
                    next_phase = mmio_pkg::PH_WRITE;
                end else if (accept) begin
                    next_phase = mmio_pkg::PH_READ_WAIT;
                end else begin
                    next_phase = mmio_pkg::PH_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= mmio_pkg::PH_IDLE;
            ph_addr <= 32'h0000_0000;
        end else begin
            phase <= next_phase;
            if (accept && phase != mmio_pkg::PH_READ_WAIT) begin
                ph_addr <= haddr;
            end
        end
    end

    assign hreadyout = (phase != mmio_pkg::PH_READ_WAIT);
    assign hresp = 1'b0;

    // Write strobes, one per register
    wire wr = (phase == mmio_pkg::PH_WRITE);
    wire wr_p1_dir = wr && (ph_addr == mmio_pkg::ADDR_P1_DIR);
    wire wr_p1_data = wr && (ph_addr == mmio_pkg::ADDR_P1_DATA);
    wire wr_p1_sel = wr && (ph_addr == mmio_pkg::ADDR_P1_SEL);
    wire wr_p2_dir = wr && (ph_addr == mmio_pkg::ADDR_P2_DIR) && !expanded;
    wire wr_p2_data = wr && (ph_addr == mmio_pkg::ADDR_P2_DATA);
    wire wr_p3_dir = wr && (ph_addr == mmio_pkg::ADDR_P3_DIR);
    wire wr_p3_data = wr && (ph_addr == mmio_pkg::ADDR_P3_DATA);
    wire [7:0] wbyte = hwdata[7:0];

    // Registers; hardware standby reinitialises, software standby does not
    logic [7:0] p1_dir;
    logic [7:0] p1_data;
    logic [7:0] p1_sel;
    logic [4:0] p2_dir;
    logic [4:0] p2_data;
    logic [7:0] p3_dir;
    logic [7:0] p3_data;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            p1_dir <= mmio_pkg::RST_P1_DIR;
            p1_data <= mmio_pkg::RST_P1_DATA;
            p1_sel <= mmio_pkg::RST_P1_SEL;
            p2_dir <= mmio_pkg::RST_P2_DIR[4:0];
            p2_data <= mmio_pkg::RST_P2_DATA[4:0];
            p3_dir <= mmio_pkg::RST_P3_DIR;
            p3_data <= mmio_pkg::RST_P3_DATA;
        end else if (hw_standby) begin
            p1_dir <= mmio_pkg::RST_P1_DIR;
            p1_data <= mmio_pkg::RST_P1_DATA;
            p1_sel <= mmio_pkg::RST_P1_SEL;
            p2_dir <= mmio_pkg::RST_P2_DIR[4:0];
            p2_data <= mmio_pkg::RST_P2_DATA[4:0];
            p3_dir <= mmio_pkg::RST_P3_DIR;
            p3_data <= mmio_pkg::RST_P3_DATA;
        end else begin
            // Software standby has no term here, so all state holds
            if (wr_p1_dir) p1_dir <= wbyte;
            if (wr_p1_data) p1_data <= wbyte;
            if (wr_p1_sel) p1_sel <= wbyte;
            if (wr_p2_dir) p2_dir <= wbyte[4:0];
            if (wr_p2_data) p2_data <= wbyte[4:0];
            if (wr_p3_dir) p3_dir <= wbyte;
            if (wr_p3_data) p3_data <= wbyte;
        end
    end

    // Port one select bits
    wire trig_en = p1_sel[mmio_pkg::SEL_TRIG_BIT];
    wire inta_en = p1_sel[mmio_pkg::SEL_INTA_BIT];
    wire intb_en = p1_sel[mmio_pkg::SEL_INTB_BIT];

    // Port one drive: pin six only as plain I/O, pin five unless interrupt A
    wire six_plain = !trig_en && !intb_en;
    logic [7:0] p1_drive;
    assign p1_drive = {p1_dir[7],
                       p1_dir[6] && six_plain,
                       p1_dir[5] && !inta_en,
                       p1_dir[4:0]};
    // Clock pins pass the clock itself, not the latch
    wire [7:0] p1_value = {p1_data[7:2], e_clock, phi_clock};

    assign p1_out = p1_value;
    assign p1_oe_n = hw_standby ? 8'hFF : ~p1_drive;

    // Pin six may feed both functions at once; idle level is high
    assign p1_func.intr_a_pin_enable = inta_en;
    assign p1_func.intr_b_pin_enable = intb_en;
    assign p1_func.conv_trigger_pin_enable = trig_en;
    assign p1_func.interrupt_input_a = inta_en ? p1_sync[mmio_pkg::P1_INTA_PIN] : 1'b1;
    assign p1_func.interrupt_input_b = intb_en ? p1_sync[mmio_pkg::P1_SIX_PIN] : 1'b1;
    assign p1_func.external_conversion_trigger = trig_en ? p1_sync[mmio_pkg::P1_SIX_PIN] : 1'b1;

    // Port two: strobes when expanded, latch when single-chip
    wire [4:0] p2_dir_eff = expanded ? 5'h1F : p2_dir;
    assign p2_out = expanded ? bus_ctl : p2_data;
    // Drive holds through software standby
    assign p2_oe_n = hw_standby ? 5'h1F : ~p2_dir_eff;

    // Port three: data bus when expanded, latch when single-chip
    assign p3_out = expanded ? ext_data_out : p3_data;
    wire [7:0] p3_drive = expanded ? {8{ext_data_drive}} : p3_dir;
    assign p3_oe_n = hw_standby ? 8'hFF : ~p3_drive;
    assign ext_data_in = p3_sync;

    // Read values: latch for outputs (port one pins one and zero give their clocks), synchronised pin for inputs
    wire [7:0] p1_rd = (p1_drive & p1_value) | (~p1_drive & p1_sync);
    wire [4:0] p2_rd = (p2_dir_eff & p2_data) | (~p2_dir_eff & p2_sync);
    wire [7:0] p3_rd = (p3_dir & p3_data) | (~p3_dir & p3_sync);

    // Read mux; unmapped reads return zero with an OKAY answer
    logic [7:0] rd_byte;
    always_comb begin
        if (ph_addr == mmio_pkg::ADDR_P1_DIR) begin
            rd_byte = mmio_pkg::ALL_ONES;
        end else if (ph_addr == mmio_pkg::ADDR_P1_DATA) begin
            rd_byte = p1_rd;
        end else if (ph_addr == mmio_pkg::ADDR_P1_SEL) begin
            rd_byte = p1_sel;
        end else if (ph_addr == mmio_pkg::ADDR_P2_DIR) begin
            rd_byte = mmio_pkg::ALL_ONES;
        end else if (ph_addr == mmio_pkg::ADDR_P2_DATA) begin
            rd_byte = {mmio_pkg::P2_RSVD_READ, p2_rd};
        end else if (ph_addr == mmio_pkg::ADDR_P3_DIR) begin
            rd_byte = mmio_pkg::ALL_ONES;
        end else if (ph_addr == mmio_pkg::ADDR_P3_DATA) begin
            rd_byte = p3_rd;
        end else begin
            rd_byte = 8'h00;
        end
    end

    // Read data captured in the wait cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (phase == mmio_pkg::PH_READ_WAIT) begin
            hrdata <= {24'h000000, rd_byte};
        end
    end

endmodule : mmio_ports

// [core/mmio_pkg.sv]
// Operation
// - Pin six function chosen by trigger enable and interrupt B enable bits
// - Pin six as general I/O follows its own direction bit
// - Pin five is interrupt input A when enabled, else direction-controlled I/O
// - Pins four to two plain I/O; pin one E clock, pin zero system clock
// - Modes one to four expanded, mode seven single-chip; ports follow mode
// - Port two has five pins: I/O in single-chip, bus control when expanded
// - Expanded: port two direction all ones, pins carry the five bus strobes
// - Single-chip: port two pin drives its latch when direction bit is one
// - Port two direction bits are write-only and read back as ones
// - Port two bits seven to five ignore writes and read as one
// - Reset and hardware standby load port two direction with its reset value
// - Software standby keeps port two direction and output drive
// - Expanded mode holds port two direction at ones, ignoring writes
// - Port two data read gives latch for outputs, pin level for inputs
// - Port three eight pins: data bus when expanded, I/O in single-chip
// - Single-chip: port three pin drives its latch when direction bit is one
// - Port three direction is write-only and reads as all ones
// - Reset and hardware standby clear port three direction
// - Software standby keeps port three direction and output drive
// - Port three data read gives latch for outputs, pin level for inputs
// - Reset and hardware standby clear port three data
package mmio_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_P1_DIR = 16'hFE80;
    localparam logic [15:0] IDX_P2_DIR = 16'hFE81;
    localparam logic [15:0] IDX_P1_DATA = 16'hFE82;
    localparam logic [15:0] IDX_P2_DATA = 16'hFE83;
    localparam logic [15:0] IDX_P3_DIR = 16'hFE84;
    localparam logic [15:0] IDX_P3_DATA = 16'hFE86;
    localparam logic [15:0] IDX_P1_SEL = 16'hFE8F;
    localparam logic [31:0] ADDR_P1_DIR = {14'h0000, IDX_P1_DIR, 2'b00};
    localparam logic [31:0] ADDR_P2_DIR = {14'h0000, IDX_P2_DIR, 2'b00};
    localparam logic [31:0] ADDR_P1_DATA = {14'h0000, IDX_P1_DATA, 2'b00};
    localparam logic [31:0] ADDR_P2_DATA = {14'h0000, IDX_P2_DATA, 2'b00};
    localparam logic [31:0] ADDR_P3_DIR = {14'h0000, IDX_P3_DIR, 2'b00};
    localparam logic [31:0] ADDR_P3_DATA = {14'h0000, IDX_P3_DATA, 2'b00};
    localparam logic [31:0] ADDR_P1_SEL = {14'h0000, IDX_P1_SEL, 2'b00};

    // Reset values
    localparam logic [7:0] RST_P1_DIR = 8'h00;
    localparam logic [7:0] RST_P1_DATA = 8'h00;
    localparam logic [7:0] RST_P1_SEL = 8'h00;
    localparam logic [7:0] RST_P2_DIR = 8'hE0;
    localparam logic [7:0] RST_P2_DATA = 8'hE0;
    localparam logic [7:0] RST_P3_DIR = 8'h00;
    localparam logic [7:0] RST_P3_DATA = 8'h00;

    // Port two layout: five live bits, three reserved that read one
    localparam int P2_WIDTH = 5;
    localparam logic [2:0] P2_RSVD_READ = 3'h7;
    localparam logic [7:0] ALL_ONES = 8'hFF;

    // Port one select register fields
    localparam int SEL_TRIG_BIT = 0;
    localparam int SEL_INTA_BIT = 5;
    localparam int SEL_INTB_BIT = 6;

    // Port one pin positions
    localparam int P1_PHI_PIN = 0;
    localparam int P1_E_PIN = 1;
    localparam int P1_INTA_PIN = 5;
    localparam int P1_SIX_PIN = 6;

    // Operating mode codes
    localparam logic [2:0] MODE_EXP_LO = 3'h1;
    localparam logic [2:0] MODE_EXP_HI = 3'h4;
    localparam logic [2:0] MODE_SINGLE = 3'h7;
    // Edges after reset release before the mode straps are trusted
    localparam logic [1:0] MODE_SETTLE = 2'h2;

    // Bus phase tracking
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_WRITE,
        PH_READ_WAIT,
        PH_READ_DONE
    } mmio_phase_e;

    // Bus control strobes from the external bus controller, pin order 4..0
    typedef struct packed {
        logic write_strobe;
        logic read_strobe;
        logic data_strobe;
        logic read_write;
        logic address_strobe;
    } mmio_busctl_s;

    // Port one pin functions handed to the interrupt and converter blocks
    typedef struct packed {
        logic intr_a_pin_enable;
        logic intr_b_pin_enable;
        logic conv_trigger_pin_enable;
        logic interrupt_input_a;
        logic interrupt_input_b;
        logic external_conversion_trigger;
    } mmio_p1func_s;

endpackage : mmio_pkg

// [bench/mmio_ports_monitor.sv]
`timescale 1ns/1ps
module mmio_ports_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Standby and pins
    input wire logic hw_standby_n,
    input wire logic sw_standby,
    input wire logic phi_clock,
    input wire logic e_clock,
    input wire mmio_pkg::mmio_p1func_s p1_func,
    input wire logic [7:0] p1_out,
    input wire logic [7:0] p1_oe_n,
    input wire logic [4:0] p2_oe_n,
    input wire logic [7:0] p3_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Accepted reads, by target
    wire rd = hsel && htrans[1] && hready && !hwrite;
    wire rd_p2d = rd && haddr == mmio_pkg::ADDR_P2_DATA;
    wire rd_dir = rd && (haddr == mmio_pkg::ADDR_P2_DIR || haddr == mmio_pkg::ADDR_P3_DIR);
    property p_resp; hresp == 1'b0; endproperty
    property p_rd; rd |=> !hreadyout ##1 hreadyout; endproperty
    property p_wr; hsel && htrans[1] && hready && hwrite |=> hreadyout; endproperty
    property p_rsvd; rd_p2d |=> ##1 hrdata[7:5] == 3'h7; endproperty
    property p_dir; rd_dir |=> ##1 hrdata == 32'h000000FF; endproperty
    property p_hws; !hw_standby_n [*4] |-> p2_oe_n == 5'h1F && p3_oe_n == 8'hFF; endproperty
    property p_inta; p1_func.intr_a_pin_enable |-> p1_oe_n[5]; endproperty
    property p_six; p1_func.intr_b_pin_enable || p1_func.conv_trigger_pin_enable |-> p1_oe_n[6]; endproperty
    property p_clk; (p1_oe_n[0] || p1_out[0] == phi_clock) && (p1_oe_n[1] || p1_out[1] == e_clock); endproperty
    property p_sws; $rose(sw_standby) && hw_standby_n |=> $stable(p2_oe_n) && $stable(p3_oe_n); endproperty
    a_resp: assert property (p_resp) else $error("hresp not OKAY");
    a_rd: assert property (p_rd) else $error("read wait cycle wrong");
    a_wr: assert property (p_wr) else $error("write stalled");
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not one");
    a_dir: assert property (p_dir) else $error("direction read not ones");
    a_hws: assert property (p_hws) else $error("standby left a pin driving");
    a_inta: assert property (p_inta) else $error("pin five driven as input");
    a_six: assert property (p_six) else $error("pin six driven as input");
    a_clk: assert property (p_clk) else $error("clock pin wrong");
    a_sws: assert property (p_sws) else $error("soft standby moved drive");
    c_rsvd: cover property (rd_p2d);
    c_sws: cover property ($rose(sw_standby));
    c_inta: cover property (p1_func.intr_a_pin_enable);
endmodule : mmio_ports_monitor
bind mmio_ports mmio_ports_monitor u_mon (.*);

// [bench/mmio_pins_model.sv]
`timescale 1ns/1ps
module mmio_pins_model (
    // Chip drive
    input wire logic [7:0] p1_out,
    input wire logic [7:0] p1_oe_n,
    input wire logic [4:0] p2_out,
    input wire logic [4:0] p2_oe_n,
    input wire logic [7:0] p3_out,
    input wire logic [7:0] p3_oe_n,
    // Outside sources
    input wire logic [7:0] x1,
    input wire logic [4:0] x2,
    input wire logic [7:0] x3,
    // Resolved line levels
    output logic [7:0] p1_in,
    output logic [4:0] p2_in,
    output logic [7:0] p3_in
);
    // No pulls: an undriven line follows the outside source, never the old chip value
    assign p1_in = (p1_oe_n & x1) | (~p1_oe_n & p1_out);
    assign p2_in = (p2_oe_n & x2) | (~p2_oe_n & p2_out);
    assign p3_in = (p3_oe_n & x3) | (~p3_oe_n & p3_out);
endmodule : mmio_pins_model

// [bench/test_mmio_ports.sv]
`timescale 1ns/1ps
module test_mmio_ports;
    // Stimulus
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] mode_pins = 3'h7;
    logic hw_standby_n = 1'b1;
    logic sw_standby = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic phi_clock = 1'b0;
    logic e_clock = 1'b0;
    mmio_pkg::mmio_busctl_s bus_ctl = 5'h0;
    logic [7:0] ext_data_out = 8'h0;
    logic ext_data_drive = 1'b0;
    logic [7:0] x1 = 8'h1A;
    logic [4:0] x2 = 5'h15;
    logic [7:0] x3 = 8'hC3;
    // Design outputs
    logic hreadyout, hresp;
    logic [31:0] hrdata;
    logic [7:0] ext_data_in, p1_in, p1_out, p1_oe_n, p3_in, p3_out, p3_oe_n;
    logic [4:0] p2_in, p2_out, p2_oe_n;
    mmio_pkg::mmio_p1func_s p1_func;
    wire hready = hreadyout;
    // Checking state
    int fail_count = 0;
    int samples_checked = 0;
    logic [31:0] exp_q [$];
    logic [31:0] rnd = 32'h9B99;
    logic rd_dph = 1'b0;
    logic [7:0] m, d;

    mmio_ports dut (.*);
    mmio_pins_model pm (.*);

    always #5 clk = ~clk;
    // Two clock sources at different rates so the pin muxes cannot confuse them
    always @(posedge clk) begin
        phi_clock <= ~phi_clock;
        if (phi_clock) begin
            e_clock <= ~e_clock;
        end
    end

    function logic [7:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd[7:0];
    endfunction : xs

    task cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : cmp

    task report_and_stop();
        // A read whose result never showed up counts against the run
        if (exp_q.size() > 0) begin
            fail_count++;
        end
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    // Bounded wait for hready; a hang ends the run
    task wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            report_and_stop();
        end
    endtask : wait_rdy

    task bus(input logic w, input logic [31:0] a, input logic [7:0] dv);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, dv};
        wait_rdy();
    endtask : bus

    task rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h0);
    endtask : rd

    task do_reset(input logic [2:0] md);
        resetn <= 1'b0;
        mode_pins <= md;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : do_reset

    // Read results are judged against the oldest note as each data phase ends
    always @(posedge clk) begin
        if (rd_dph && hreadyout === 1'b1 && exp_q.size() > 0) begin
            cmp("hrdata", exp_q.pop_front(), hrdata);
        end
        if (hreadyout === 1'b1) begin
            rd_dph = hsel && htrans[1] && !hwrite;
        end
    end

    initial begin
        do_reset(3'h7);
        cmp("p2_oe_n", 5'h1F, p2_oe_n);
        cmp("p3_oe_n", 8'hFF, p3_oe_n);
        rd(mmio_pkg::ADDR_P2_DATA, {24'h0, 3'h7, x2});
        rd(32'h0, 32'h0);
        // Random latches and directions; reads mix latch and line level
        repeat (4) begin
            d = xs();
            m = xs();
            x3 <= xs();
            x2 <= rnd[12:8];
            bus_ctl <= rnd[20:16];
            ext_data_out <= rnd[31:24];
            bus(1'b1, mmio_pkg::ADDR_P2_DATA, d);
            bus(1'b1, mmio_pkg::ADDR_P2_DIR, m);
            bus(1'b1, mmio_pkg::ADDR_P3_DATA, m);
            bus(1'b1, mmio_pkg::ADDR_P3_DIR, d);
            rd(mmio_pkg::ADDR_P2_DIR, 32'hFF);
            rd(mmio_pkg::ADDR_P3_DIR, 32'hFF);
            rd(mmio_pkg::ADDR_P2_DATA, {24'h0, 3'h7, (d[4:0] & m[4:0]) | (x2 & ~m[4:0])});
            rd(mmio_pkg::ADDR_P3_DATA, {24'h0, (m & d) | (x3 & ~d)});
            cmp("p2_oe_n", {~m[4:0]}, p2_oe_n);
            cmp("p2_out", d[4:0] & m[4:0], p2_out & m[4:0]);
            cmp("p3_oe_n", {~d}, p3_oe_n);
            cmp("p3_out", m & d, p3_out & d);
        end
        // Software standby keeps directions and drive
        sw_standby <= 1'b1;
        repeat (3) @(posedge clk);
        cmp("p2_oe_n", {~m[4:0]}, p2_oe_n);
        cmp("p3_out", m & d, p3_out & d);
        sw_standby <= 1'b0;
        // Port one select bit combinations
        bus(1'b1, mmio_pkg::ADDR_P1_DIR, 8'h63);
        for (int i = 0; i < 4; i++) begin
            d = {1'b0, i[1], i[0] ^ i[1], 4'h0, i[0]};
            bus(1'b1, mmio_pkg::ADDR_P1_SEL, d);
            // Pin inputs reach the function outputs two edges late
            repeat (3) @(posedge clk);
            cmp("pin6 oe_n", d[6] | d[0], p1_oe_n[6]);
            cmp("pin5 oe_n", d[5], p1_oe_n[5]);
            cmp("p1_func", {d[5], d[6], d[0]}, p1_func[5:3]);
            cmp("p1_func in", {d[5] ? x1[5] : 1'b1, d[6] ? x1[6] : 1'b1, d[0] ? x1[6] : 1'b1}, p1_func[2:0]);
            cmp("p1 low pins", {3'h7, 2'h0, e_clock, phi_clock}, {p1_oe_n[4:0], p1_out[1:0]});
        end
        // Hardware standby restores reset state
        hw_standby_n <= 1'b0;
        repeat (5) @(posedge clk);
        hw_standby_n <= 1'b1;
        repeat (4) @(posedge clk);
        cmp("p3_oe_n", 8'hFF, p3_oe_n);
        cmp("p2_oe_n", 5'h1F, p2_oe_n);
        bus(1'b1, mmio_pkg::ADDR_P3_DIR, 8'hFF);
        @(posedge clk);
        cmp("p3_out", 8'h00, p3_out);
        // Expanded mode: strobes on port two, data bus on port three
        do_reset(3'h2);
        bus(1'b1, mmio_pkg::ADDR_P2_DIR, 8'h00);
        bus(1'b1, mmio_pkg::ADDR_P3_DIR, 8'hFF);
        ext_data_drive <= 1'b1;
        repeat (2) @(posedge clk);
        cmp("p2_oe_n", 5'h00, p2_oe_n);
        cmp("p2_out", bus_ctl, p2_out);
        cmp("p3 bus drive", {8'h00, ext_data_out}, {p3_oe_n, p3_out});
        ext_data_drive <= 1'b0;
        repeat (4) @(posedge clk);
        cmp("p3 bus idle", {8'hFF, x3}, {p3_oe_n, ext_data_in});
        rd(mmio_pkg::ADDR_P2_DIR, 32'hFF);
        repeat (2) @(posedge clk);
        // Mode edges: one and four expand, five stays single-chip
        do_reset(3'h1);
        cmp("p2_oe_n mode1", 5'h00, p2_oe_n);
        do_reset(3'h4);
        cmp("p2_oe_n mode4", 5'h00, p2_oe_n);
        do_reset(3'h5);
        cmp("p2_oe_n mode5", 5'h1F, p2_oe_n);
        report_and_stop();
    end
endmodule : test_mmio_ports
